// File: sdas_pkg.sv
package sdas_pkg;
    localparam logic [3:0] PORT_A_OFS = 4'h0;
    localparam logic [3:0] PORT_B_OFS = 4'h4;
    localparam logic [3:0] PORT_C_OFS = 4'h8;
    localparam logic [3:0] MREG_CTRL = 4'h0;
    localparam logic [3:0] MREG_CFG1A = 4'h1;
    localparam logic [3:0] MREG_DATA1 = 4'h7;
    localparam logic [3:0] MREG_PRESC = 4'ha;
    localparam int CTRL_CNV_LSB = 0;
    localparam int CTRL_SE_LSB = 4;
    localparam int CFGA_RES_LSB = 0;
    localparam int CFGA_GAIN_LSB = 3;
    localparam int CFGA_COFS_LSB = 8;
    localparam int CFGB_BIAS_LSB = 0;
    localparam int CFGB_REF_LSB = 3;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [9:0] PRESC_RST = 10'h004;
    localparam logic [9:0] PRESC_MIN = 10'h004;
    localparam logic [9:0] PRESC_MAX = 10'h200;
    localparam logic [3:0] RES_MIN_BITS = 4'h9;
    localparam logic [3:0] SE_FIXED_FIRST = 4'h9;
    localparam logic [1:0] REF_BG4 = 2'h2;
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN = 3'b010,
        S_DONE = 3'b100
    } sdas_state_t;
endpackage : sdas_pkg

// File: sdas_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_prescale
    import sdas_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [9:0] div,
    output logic tick,
    output logic adc_clk
);
    logic [9:0] div_eff;
    logic [9:0] cnt_q;
    logic ck_q;

    // Out-of-range divisors are clamped rather than rejected.
    always_comb begin
        if (div < PRESC_MIN) begin
            div_eff = PRESC_MIN;
        end else if (div > PRESC_MAX) begin
            div_eff = PRESC_MAX;
        end else begin
            div_eff = div;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !run) begin
            cnt_q <= 10'h000;
        end else if (cnt_q == div_eff - 10'h001) begin
            cnt_q <= 10'h000;
        end else begin
            cnt_q <= cnt_q + 10'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ck_q <= 1'b0;
        end else begin
            ck_q <= run && (cnt_q < (div_eff >> 1));
        end
    end

    assign tick = run && (cnt_q == div_eff - 10'h001);
    assign adc_clk = ck_q;
endmodule : sdas_prescale
`default_nettype wire

// File: sdas_decim.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_decim
    import sdas_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic tick,
    input wire logic mod_bit,
    input wire logic [2:0] res,
    input wire logic [2:0] bias,
    output logic done,
    output logic [15:0] result
);
    logic busy_q;
    logic done_q;
    logic [16:0] cnt_q;
    logic [2:0] round_q;
    logic signed [17:0] acc_q;
    logic signed [17:0] acc_d;
    logic signed [24:0] scaled;
    logic [16:0] limit;
    logic last;
    logic [15:0] res_q;

    // A conversion takes 2^(res+9) converter clocks per round.
    assign limit = 17'h00001 << ({2'b00, res} + 5'(RES_MIN_BITS));
    // Higher bias adds whole rounds after the accumulating round 0, so it only ever lengthens it.
    assign last = busy_q && tick && (cnt_q == limit - 17'h00001) && (round_q == bias);

    always_comb begin
        acc_d = acc_q;
        if (busy_q && tick && round_q == 3'h0) begin
            acc_d = mod_bit ? acc_q + 18'sd1 : acc_q - 18'sd1;
        end
        scaled = 25'(acc_d) <<< (3'h7 - res);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            cnt_q <= 17'h00000;
            round_q <= 3'h0;
            acc_q <= 18'sd0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q <= 17'h00000;
            round_q <= 3'h0;
            acc_q <= 18'sd0;
        end else if (busy_q && tick) begin
            acc_q <= acc_d;
            if (cnt_q == limit - 17'h00001) begin
                cnt_q <= 17'h00000;
                round_q <= round_q + 3'h1;
                busy_q <= !last;
            end else begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
    end

    // Full-scale positive and negative both saturate so the word stays 16-bit signed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            res_q <= 16'h0000;
        end else begin
            done_q <= last;
            if (last) begin
                if (scaled > 25'sd32767) begin
                    res_q <= 16'h7fff;
                end else if (scaled < -25'sd32768) begin
                    res_q <= 16'h8000;
                end else begin
                    res_q <= scaled[15:0];
                end
            end
        end
    end

    assign done = done_q;
    assign result = res_q;
endmodule : sdas_decim
`default_nettype wire

// File: sdas_seq.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_seq
    import sdas_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic MOD_BIT,
    output logic ADC_CLK,
    output logic MOD_ENABLE,
    output logic CPU_HALT,
    output logic [1:0] CHAN_SELECT,
    output logic [3:0] SINGLE_ENDED_SELECT,
    output logic [4:0] PGA_GAIN,
    output logic GAIN_FIXED,
    output logic [5:0] COARSE_OFFSET,
    output logic [2:0] BIAS_LEVEL_SELECT,
    output logic [1:0] REFERENCE_SELECT
);
    sdas_state_t state_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [3:0] port_a_q;
    logic [15:0] ctrl_q;
    logic [9:0] presc_q;
    logic [15:0] cfg_a_q [3];
    logic [15:0] cfg_b_q [3];
    logic [15:0] data_q [3];
    logic [1:0] chan_q;
    logic mod_s1_q;
    logic mod_s2_q;
    logic [1:0] chan_out_q;
    logic [3:0] se_out_q;
    logic [4:0] gain_out_q;
    logic fixed_out_q;
    logic [5:0] cofs_out_q;
    logic [2:0] bias_out_q;
    logic [1:0] ref_out_q;
    logic wb_req;
    logic wb_wr;
    logic mwr;
    logic [15:0] mwdata;
    logic [2:0] cnv_req;
    logic start;
    logic tick;
    logic dec_done;
    logic [15:0] dec_result;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] presc_wr;
    logic [2:0] run_res;
    logic [2:0] run_bias;
    logic se_fixed;

    // Byte-lane merge of a 16-bit module register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] sel);
        merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
    endfunction : merge16

    // Module index of a channel's configuration register (b selects the second).
    function automatic logic [3:0] cfg_index(input int c, input logic b);
        cfg_index = 4'(MREG_CFG1A + 2 * c + (b ? 1 : 0));
    endfunction : cfg_index

    function automatic logic [15:0] pick(input logic [15:0] r0, input logic [15:0] r1,
                                         input logic [15:0] r2, input logic [1:0] c);
        case (c)
            2'h0: pick = r0;
            2'h1: pick = r1;
            2'h2: pick = r2;
            default: pick = 16'h0000;
        endcase
    endfunction : pick

    // Convert bits are granted to channel one first, then two, then temperature.
    function automatic logic [1:0] first_chan(input logic [2:0] req);
        if (req[0]) begin
            first_chan = 2'h0;
        end else if (req[1]) begin
            first_chan = 2'h1;
        end else begin
            first_chan = 2'h2;
        end
    endfunction : first_chan

    // Unlisted module indices read as zero.
    function automatic logic [15:0] mreg_read(input logic [3:0] idx);
        mreg_read = 16'h0000;
        for (int c = 0; c < 3; c++) begin
            if (idx == cfg_index(c, 1'b0)) begin
                mreg_read = cfg_a_q[c];
            end
            if (idx == cfg_index(c, 1'b1)) begin
                mreg_read = cfg_b_q[c];
            end
            if (idx == 4'(MREG_DATA1 + c)) begin
                mreg_read = data_q[c];
            end
        end
        if (idx == MREG_CTRL) begin
            mreg_read = ctrl_q;
        end
        if (idx == MREG_PRESC) begin
            mreg_read = {6'h00, presc_q};
        end
    endfunction : mreg_read

    // Bus side: one wait state, then ack for exactly one cycle.
    assign wb_req = WB_CYC_I && WB_STB_I;
    assign wb_wr = wb_req && WB_WE_I && ack_q;
    // Module registers are never decoded directly; port A points, port C moves data.
    assign mwr = wb_wr && (WB_ADR_I == PORT_C_OFS);
    assign mwdata = WB_DAT_I[15:0];
    // Only the low ten bits of the prescaler word are stored; the rest read as zero.
    assign presc_wr = merge16({6'h00, presc_q}, mwdata, WB_SEL_I[1:0]);
    assign cnv_req = mwdata[CTRL_CNV_LSB +: 3];
    // Start only from a control write that carries a convert bit.
    assign start = mwr && (port_a_q == MREG_CTRL) && WB_SEL_I[0] && (cnv_req != 3'h0)
                   && (state_q == S_IDLE);

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= wb_req && !ack_q;
            if (wb_req && !ack_q && !WB_WE_I) begin
                case (WB_ADR_I)
                    PORT_A_OFS: dat_q <= {28'h0000000, port_a_q};
                    PORT_B_OFS: dat_q <= {28'h0000000, state_q != S_IDLE, 1'b0, chan_q};
                    PORT_C_OFS: dat_q <= {16'h0000, mreg_read(port_a_q)};
                    default: dat_q <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            port_a_q <= 4'h0;
        end else if (wb_wr && WB_ADR_I == PORT_A_OFS && WB_SEL_I[0]) begin
            port_a_q <= WB_DAT_I[3:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_q <= CTRL_RST;
        end else if (dec_done) begin
            ctrl_q[CTRL_CNV_LSB +: 3] <= 3'h0;
        end else if (mwr && port_a_q == MREG_CTRL) begin
            ctrl_q <= merge16(ctrl_q, mwdata, WB_SEL_I[1:0]);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            presc_q <= PRESC_RST;
        end else if (mwr && port_a_q == MREG_PRESC) begin
            presc_q <= presc_wr[9:0];
        end
    end

    // Each of the three channels owns two settings words and one result.
    for (genvar c = 0; c < 3; c++) begin : g_ch
        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                cfg_a_q[c] <= CFG_RST;
                cfg_b_q[c] <= CFG_RST;
            end else if (mwr) begin
                if (port_a_q == cfg_index(c, 1'b0)) begin
                    cfg_a_q[c] <= merge16(cfg_a_q[c], mwdata, WB_SEL_I[1:0]);
                end
                if (port_a_q == cfg_index(c, 1'b1)) begin
                    cfg_b_q[c] <= merge16(cfg_b_q[c], mwdata, WB_SEL_I[1:0]);
                end
            end
        end

        always_ff @(posedge CLK) begin
            if (!RESET_N) begin
                data_q[c] <= 16'h0000;
            end else if (dec_done && chan_q == 2'(c)) begin
                data_q[c] <= dec_result;
            end
        end
    end

    // Channel one wins when software sets several convert bits at once.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            state_q <= S_IDLE;
            chan_q <= 2'h0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        state_q <= S_RUN;
                        chan_q <= first_chan(cnv_req);
                    end
                end
                S_RUN: begin
                    if (dec_done) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    assign cur_a = pick(cfg_a_q[0], cfg_a_q[1], cfg_a_q[2], chan_q);
    assign cur_b = pick(cfg_b_q[0], cfg_b_q[1], cfg_b_q[2], chan_q);

    // The decimator follows the latched channel, not bus data that may move during a run.
    assign run_res = cur_a[CFGA_RES_LSB +: 3];
    assign run_bias = cur_b[CFGB_BIAS_LSB +: 3];
    assign se_fixed = ctrl_q[CTRL_SE_LSB +: 4] >= SE_FIXED_FIRST;

    // Front-end settings are registered so the analog side never sees decode glitches.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            chan_out_q <= 2'h0;
            se_out_q <= 4'h0;
            gain_out_q <= 5'h00;
            fixed_out_q <= 1'b0;
            cofs_out_q <= 6'h00;
            bias_out_q <= 3'h0;
            ref_out_q <= 2'h0;
        end else begin
            chan_out_q <= chan_q;
            // Single-ended routing only exists on channels one and two.
            se_out_q <= (chan_q == 2'h2) ? 4'h0 : ctrl_q[CTRL_SE_LSB +: 4];
            gain_out_q <= cur_a[CFGA_GAIN_LSB +: 5];
            fixed_out_q <= (chan_q != 2'h2) && se_fixed;
            cofs_out_q <= cur_a[CFGA_COFS_LSB +: 6];
            bias_out_q <= cur_b[CFGB_BIAS_LSB +: 3];
            ref_out_q <= (chan_q == 2'h2) ? REF_BG4 : cur_b[CFGB_REF_LSB +: 2];
        end
    end

    // The modulator bit is asynchronous to CLK.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
        end else begin
            mod_s1_q <= MOD_BIT;
            mod_s2_q <= mod_s1_q;
        end
    end

    sdas_prescale u_presc (
        .clk(CLK),
        .rst_n(RESET_N),
        .run(state_q == S_RUN),
        .div(presc_q),
        .tick(tick),
        .adc_clk(ADC_CLK)
    );

    sdas_decim u_decim (
        .clk(CLK),
        .rst_n(RESET_N),
        .start(state_q == S_IDLE && start),
        .tick(tick),
        .mod_bit(mod_s2_q),
        .res(run_res),
        .bias(run_bias),
        .done(dec_done),
        .result(dec_result)
    );

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign MOD_ENABLE = (state_q == S_RUN);
    // Halt covers the whole run and the latch cycle, then drops.
    assign CPU_HALT = (state_q != S_IDLE);
    assign CHAN_SELECT = chan_out_q;
    assign SINGLE_ENDED_SELECT = se_out_q;
    assign PGA_GAIN = gain_out_q;
    assign GAIN_FIXED = fixed_out_q;
    assign COARSE_OFFSET = cofs_out_q;
    assign BIAS_LEVEL_SELECT = bias_out_q;
    assign REFERENCE_SELECT = ref_out_q;
endmodule : sdas_seq
`default_nettype wire

// File: sdas_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_seq_checker
    import sdas_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic ADC_CLK,
    input wire logic MOD_ENABLE,
    input wire logic CPU_HALT,
    input wire logic [1:0] CHAN_SELECT,
    input wire logic [3:0] SINGLE_ENDED_SELECT,
    input wire logic GAIN_FIXED,
    input wire logic [1:0] REFERENCE_SELECT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic [3:0] idx_q;
    logic [15:0] halt_cnt_q;
    logic start_wr;
    logic req;
    assign req = WB_CYC_I && WB_STB_I;
    assign start_wr = req && WB_ACK_O && WB_WE_I && WB_ADR_I == PORT_C_OFS && WB_SEL_I[0]
        && idx_q == MREG_CTRL && |WB_DAT_I[2:0];
    // The module index is tracked here because the start command is a port C write.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            idx_q <= 4'h0;
        end else if (req && WB_ACK_O && WB_WE_I && WB_ADR_I == PORT_A_OFS && WB_SEL_I[0]) begin
            idx_q <= WB_DAT_I[3:0];
        end
    end
    // Saturates so that a very long conversion never wraps to a small count.
    always_ff @(posedge CLK) begin
        if (!RESET_N || !CPU_HALT) begin
            halt_cnt_q <= 16'h0000;
        end else if (halt_cnt_q != 16'hffff) begin
            halt_cnt_q <= halt_cnt_q + 16'h0001;
        end
    end
    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    halt_start_a: assert property (start_wr && !CPU_HALT |-> ##[1:2] CPU_HALT)
        else $error("halt did not follow convert write");
    halt_cause_a: assert property ($rose(CPU_HALT)
        |-> $past(start_wr) || $past(start_wr, 2))
        else $error("halt rose without convert write");
    conv_in_halt_a: assert property (MOD_ENABLE |-> CPU_HALT)
        else $error("converting while cpu runs");
    halt_release_a: assert property ($fell(MOD_ENABLE) |-> CPU_HALT ##[1:2] !CPU_HALT)
        else $error("halt not released after completion");
    halt_length_a: assert property ($fell(CPU_HALT) |-> halt_cnt_q >= 16'd2040)
        else $error("conversion shorter than minimum");
    clk_idle_a: assert property (!MOD_ENABLE && !$past(MOD_ENABLE) |-> !ADC_CLK)
        else $error("converter clock runs while idle");
    temp_ref_a: assert property (MOD_ENABLE && $past(MOD_ENABLE, 2)
        && CHAN_SELECT == 2'h2 |-> REFERENCE_SELECT == REF_BG4)
        else $error("temperature channel not on bandgap reference");
    gain_fixed_a: assert property (MOD_ENABLE && $past(MOD_ENABLE, 2)
        && CHAN_SELECT != 2'h2 |-> GAIN_FIXED == (SINGLE_ENDED_SELECT >= SE_FIXED_FIRST))
        else $error("fixed gain flag wrong for selection");
    cover property ($fell(CPU_HALT));
    cover property (MOD_ENABLE && CHAN_SELECT == 2'h2);
    cover property (MOD_ENABLE && GAIN_FIXED);
endmodule : sdas_seq_checker
bind sdas_seq sdas_seq_checker sdas_seq_checker_inst (.CLK(CLK), .RESET_N(RESET_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .ADC_CLK(ADC_CLK),
    .MOD_ENABLE(MOD_ENABLE), .CPU_HALT(CPU_HALT), .CHAN_SELECT(CHAN_SELECT),
    .SINGLE_ENDED_SELECT(SINGLE_ENDED_SELECT), .GAIN_FIXED(GAIN_FIXED),
    .REFERENCE_SELECT(REFERENCE_SELECT));
`default_nettype wire

// File: sdas_mod_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_mod_model (
    input wire logic clk,
    input wire logic enable,
    input wire logic level,
    output logic mod_bit
);
    initial mod_bit = 1'b0;
    // Outside a conversion the bitstream toggles so a stale level is never counted.
    always @(posedge clk) begin
        mod_bit <= (enable === 1'b1) ? level : ~mod_bit;
    end
endmodule : sdas_mod_model
`default_nettype wire

// File: sdas_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdas_seq_tb_top
    import sdas_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, level = 1'b0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, mod_bit, adc_clk, mod_en, halt, gfix;
    logic [1:0] chan, refs;
    logic [3:0] se_out;
    logic [4:0] gain;
    logic [5:0] cofs;
    logic [2:0] bias;
    logic [4:0] gain_t [3] = '{5'h0a, 5'h13, 5'h1f};
    logic [5:0] cofs_t [3] = '{6'h15, 6'h2a, 6'h3f};
    logic [2:0] bias_t [3] = '{3'h1, 3'h0, 3'h0};
    logic [1:0] ref_t [3] = '{2'h1, 2'h0, 2'h0};
    logic [15:0] res_t [3] = '{16'h0, 16'h0, 16'h0};
    logic [2:0] rsl_t [3] = '{3'h0, 3'h0, 3'h1};
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    sdas_seq sdas_seq_inst (.CLK(clk), .RESET_N(reset_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .MOD_BIT(mod_bit), .ADC_CLK(adc_clk), .MOD_ENABLE(mod_en),
        .CPU_HALT(halt), .CHAN_SELECT(chan), .SINGLE_ENDED_SELECT(se_out), .PGA_GAIN(gain),
        .GAIN_FIXED(gfix), .COARSE_OFFSET(cofs), .BIAS_LEVEL_SELECT(bias),
        .REFERENCE_SELECT(refs));
    sdas_mod_model sdas_mod_model_inst (.clk(clk), .enable(mod_en), .level(level),
        .mod_bit(mod_bit));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic mwr(input logic [3:0] i, input logic [15:0] v);
        logic [31:0] q;
        wb(1'b1, PORT_A_OFS, {28'h0, i}, q);
        wb(1'b1, PORT_C_OFS, {16'h0, v}, q);
    endtask : mwr
    task automatic mrd(input logic [3:0] i, output logic [31:0] q);
        wb(1'b1, PORT_A_OFS, {28'h0, i}, q);
        wb(1'b0, PORT_C_OFS, 32'h0, q);
    endtask : mrd
    task automatic convert(input int c, input logic [3:0] se, input logic lv,
                           input logic [15:0] ex);
        logic [31:0] q;
        int n;
        int exp_n;
        exp_n = int'(PRESC_MIN) * (512 << rsl_t[c]) * (int'(bias_t[c]) + 1);
        level <= lv;
        mwr(MREG_CTRL, {8'h0, se, 4'h0} | (16'h1 << c));
        repeat (4) @(posedge clk);
        check(32'(halt), 32'h1);
        check(32'(chan), 32'(c));
        check(32'(cofs), 32'(cofs_t[c]));
        check(32'(bias), 32'(bias_t[c]));
        check(32'(refs), (c == 2) ? 32'(REF_BG4) : 32'(ref_t[c]));
        check(32'(se_out), (c == 2) ? 32'h0 : 32'(se));
        check(32'(gfix), 32'(c < 2 && se >= SE_FIXED_FIRST));
        if (c == 2 || se < SE_FIXED_FIRST) begin
            check(32'(gain), 32'(gain_t[c]));
        end
        wb(1'b0, PORT_B_OFS, 32'h0, q);
        check(q, 32'h8 | 32'(c));
        n = 0;
        while (halt !== 1'b0) begin
            @(posedge clk);
            n++;
        end
        check(32'(n <= exp_n && n + 8 >= exp_n), 32'h1);
        @(posedge clk);
        res_t[c] = ex;
        mrd(MREG_CTRL, q);
        check(q, 32'({se, 4'h0}));
        for (int k = 0; k < 3; k++) begin
            mrd(MREG_DATA1 + 4'(k), q);
            check(q, {16'h0, res_t[k]});
        end
    endtask : convert
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        logic [31:0] q;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i <= 10; i++) begin
            mrd(4'(i), q);
            check(q, (i == 10) ? 32'h4 : 32'h0);
        end
        for (int c = 0; c < 3; c++) begin
            mwr(MREG_CFG1A + 4'(2 * c), {2'h0, cofs_t[c], gain_t[c], rsl_t[c]});
            mwr(MREG_CFG1A + 4'(2 * c + 1), {11'h0, ref_t[c], bias_t[c]});
            mrd(MREG_CFG1A + 4'(2 * c), q);
            check(q, {18'h0, cofs_t[c], gain_t[c], rsl_t[c]});
            mrd(MREG_CFG1A + 4'(2 * c + 1), q);
            check(q, {27'h0, ref_t[c], bias_t[c]});
        end
        mwr(MREG_PRESC, 16'h0200);
        mrd(MREG_PRESC, q);
        check(q, 32'h200);
        mwr(MREG_PRESC, 16'h0004);
        wb(1'b0, 4'hc, 32'h0, q);
        check(q, 32'h0);
        convert(0, 4'h3, 1'b1, 16'h7fff);
        convert(1, SE_FIXED_FIRST, 1'b0, 16'h8000);
        convert(2, SE_FIXED_FIRST, 1'b1, 16'h7fff);
        mwr(MREG_DATA1, 16'h1234);
        mrd(MREG_DATA1, q);
        check(q, 32'h7fff);
        test_done();
    end
endmodule : sdas_seq_tb_top
`default_nettype wire
